// >>> cpu_instruction_execution.sv
// Instruction execution core with APB register access
`timescale 1ns/1ps
`include "core_exec_params.svh"
module cpu_instruction_execution
    import core_exec_pkg::*;
#(
    parameter int FILE_DEPTH = 256
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] hw_flag_set,
    output logic exec_done
);

    // Phase enables
    logic q1;
    logic q2;
    logic q3;
    logic q4;

    // Bus visible state
    logic run_reg;
    logic [15:0] pend_instr_reg;
    logic pend_valid_reg;
    logic [7:0] faddr_reg;

    // Core state
    logic [7:0] work_reg;
    logic [7:0] alustat_reg;
    logic [7:0] pcl_reg;
    logic [7:0] pch_reg;
    logic [7:0] program_counter_high_holding_latch_reg;
    logic [7:0] hwflag_reg;
    logic [7:0] hwpend_reg;
    logic [7:0] hwpend_next;
    logic [7:0] file_mem [FILE_DEPTH];

    // Execution pipeline state
    logic exec_valid_reg;
    kind_t kind_reg;
    logic [7:0] fa_reg;
    logic dsel_reg;
    logic [2:0] bit_reg;
    logic [7:0] opnd_reg;
    logic [7:0] res_reg;
    logic [7:0] flags_reg;
    logic [7:0] fmask_reg;
    logic wr_f_reg;
    logic wr_w_reg;

    // Bus handshake
    logic access;
    logic commit;
    logic can_accept;
    logic known_addr;
    logic [31:0] rdata_mux;

    // Add with flag generation: {ov, z, dc, c, sum}
    function automatic logic [11:0] add8(input logic [7:0] a,
                                         input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] lo;
        logic ov;
        s = {1'b0, a} + {1'b0, b};
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        ov = (a[7] == b[7]) && (s[7] != a[7]);
        return {ov, (s[7:0] == `RST_BYTE), lo[4], s[8], s[7:0]};
    endfunction

    // Opcode decode; reserved codes run as no operation
    function automatic kind_t decode(input logic [7:0] op);
        casez (op)
            `OP_NEGATE_WORKING_INSTRUCTION: decode = K_NEGATE_WORKING_INSTRUCTION;
            `OP_CLRF: decode = K_CLRF;
            `OP_MOVWF: decode = K_MOVWF;
            `OP_MOVFW: decode = K_MOVFW;
            `OP_INCF: decode = K_INCF;
            `OP_BSF: decode = K_BSF;
            `OP_BCF: decode = K_BCF;
            `OP_BTG: decode = K_BTG;
            default: decode = K_NOP;
        endcase
    endfunction

    // File register read path
    function automatic logic [7:0] file_read(input logic [7:0] a);
        case (a)
            `FA_PCL: file_read = pcl_reg;
            `FA_PROGRAM_COUNTER_HIGH_HOLDING_LATCH: file_read = program_counter_high_holding_latch_reg;
            `FA_ALUSTAT: file_read = alustat_reg;
            `FA_HWFLAG: file_read = hwflag_reg;
            default: file_read = file_mem[a];
        endcase
    endfunction

    // Phase sequencer, one pclk per phase
    q_phase_gen q_phase_gen_i (
        .clk(pclk),
        .rst_n(presetn),
        .run(run_reg),
        .q1(q1),
        .q2(q2),
        .q3(q3),
        .q4(q4)
    );

    // Bus decode; some writes stall while the core is busy
    assign access = psel && penable;
    assign commit = access && pready;
    always_comb begin
        known_addr = 1'b1;
        can_accept = 1'b1;
        rdata_mux = `RST_WORD;
        case (paddr)
            `OFS_CTRL: rdata_mux = {31'b0, run_reg};
            `OFS_INSTR: begin
                rdata_mux = {15'b0, pend_valid_reg, pend_instr_reg};
                can_accept = !(pwrite && pend_valid_reg);
            end
            `OFS_WORK: begin
                rdata_mux = {24'b0, work_reg};
                can_accept = !(pwrite && exec_valid_reg);
            end
            `OFS_STAT: rdata_mux = {24'b0, alustat_reg};
            `OFS_PC: rdata_mux = {8'b0, program_counter_high_holding_latch_reg, pch_reg, pcl_reg};
            `OFS_FADDR: rdata_mux = {24'b0, faddr_reg};
            `OFS_FDATA: begin
                rdata_mux = {24'b0, file_read(faddr_reg)};
                can_accept = !(pwrite && exec_valid_reg);
            end
            `OFS_HWFLAG: rdata_mux = {24'b0, hwflag_reg};
            default: known_addr = 1'b0;
        endcase
    end

    // Bus answer, one wait state at least
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `RST_WORD;
        end else if (access && !pready && can_accept) begin
            pready <= 1'b1;
            pslverr <= !known_addr;
            prdata <= pwrite ? `RST_WORD : rdata_mux;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control and file pointer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= 1'b0;
            faddr_reg <= `RST_BYTE;
        end else if (commit && pwrite) begin
            if (paddr == `OFS_CTRL) begin
                run_reg <= pwdata[`CTRL_RUN_BIT];
            end
            if (paddr == `OFS_FADDR) begin
                faddr_reg <= pwdata[7:0];
            end
        end
    end

    // Instruction holding slot, emptied at decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_instr_reg <= `RST_INSTR;
            pend_valid_reg <= 1'b0;
        end else if (commit && pwrite && paddr == `OFS_INSTR) begin
            pend_instr_reg <= pwdata[15:0];
            pend_valid_reg <= 1'b1;
        end else if (q1) begin
            pend_valid_reg <= 1'b0;
        end
    end

    // Phase one: decode, or force no operation when empty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_valid_reg <= 1'b0;
            kind_reg <= K_NOP;
            fa_reg <= `RST_BYTE;
            dsel_reg <= 1'b0;
            bit_reg <= 3'b000;
        end else if (q1) begin
            exec_valid_reg <= pend_valid_reg;
            kind_reg <= pend_valid_reg ? decode(pend_instr_reg[15:8])
                                       : K_NOP;
            fa_reg <= pend_instr_reg[7:0];
            dsel_reg <= pend_instr_reg[8];
            bit_reg <= pend_instr_reg[10:8];
        end else if (q4) begin
            exec_valid_reg <= 1'b0;
        end
    end

    // Phase two: operand read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opnd_reg <= `RST_BYTE;
        end else if (q2) begin
            opnd_reg <= file_read(fa_reg);
        end
    end

    // Phase three: process data and form flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_reg <= `RST_BYTE;
            flags_reg <= `RST_BYTE;
            fmask_reg <= `FMASK_NONE;
            wr_f_reg <= 1'b0;
            wr_w_reg <= 1'b0;
        end else if (q3) begin
            res_reg <= opnd_reg;
            flags_reg <= `RST_BYTE;
            fmask_reg <= `FMASK_NONE;
            wr_f_reg <= 1'b0;
            wr_w_reg <= 1'b0;
            case (kind_reg)
                K_NEGATE_WORKING_INSTRUCTION: begin
                    // Two's complement as ~w + 1, all four flags
                    // Upper flag bits stay cleared from the default above
                    {flags_reg[3:0], res_reg} <= add8(~work_reg, `ONE_BYTE);
                    fmask_reg <= `FMASK_ALL;
                    wr_f_reg <= 1'b1;
                    wr_w_reg <= !dsel_reg;
                end
                K_CLRF: begin
                    res_reg <= `RST_BYTE;
                    flags_reg <= `FMASK_Z;
                    fmask_reg <= `FMASK_Z;
                    wr_f_reg <= 1'b1;
                    wr_w_reg <= !dsel_reg;
                end
                K_MOVWF: begin
                    res_reg <= work_reg;
                    wr_f_reg <= 1'b1;
                end
                K_MOVFW: begin
                    wr_w_reg <= 1'b1;
                end
                K_INCF: begin
                    {flags_reg[3:0], res_reg} <= add8(opnd_reg, `ONE_BYTE);
                    fmask_reg <= `FMASK_ALL;
                    wr_f_reg <= dsel_reg;
                    wr_w_reg <= !dsel_reg;
                end
                K_BSF: begin
                    res_reg <= opnd_reg | (`ONE_BYTE << bit_reg);
                    wr_f_reg <= 1'b1;
                end
                K_BCF: begin
                    res_reg <= opnd_reg & ~(`ONE_BYTE << bit_reg);
                    wr_f_reg <= 1'b1;
                end
                K_BTG: begin
                    res_reg <= opnd_reg ^ (`ONE_BYTE << bit_reg);
                    wr_f_reg <= 1'b1;
                end
                default: begin
                    wr_f_reg <= 1'b0;
                end
            endcase
        end
    end

    // Working register: phase four result or bus write when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_reg <= `RST_BYTE;
        end else if (q4 && exec_valid_reg && wr_w_reg) begin
            work_reg <= res_reg;
        end else if (commit && pwrite && paddr == `OFS_WORK) begin
            work_reg <= pwdata[7:0];
        end
    end

    // Arithmetic status: written bits, then flags override
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alustat_reg <= `RST_BYTE;
        end else if (q4 && exec_valid_reg) begin
            if (wr_f_reg && fa_reg == `FA_ALUSTAT) begin
                alustat_reg <= (res_reg & ~fmask_reg)
                             | (flags_reg & fmask_reg);
            end else begin
                alustat_reg <= (alustat_reg & ~fmask_reg)
                             | (flags_reg & fmask_reg);
            end
        end
    end

    // Program counter: low write takes high from latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcl_reg <= `RST_BYTE;
            pch_reg <= `RST_BYTE;
        end else if (q4 && exec_valid_reg) begin
            if (wr_f_reg && fa_reg == `FA_PCL) begin
                pcl_reg <= res_reg;
                pch_reg <= program_counter_high_holding_latch_reg;
            end else begin
                {pch_reg, pcl_reg} <= {pch_reg, pcl_reg} + 16'h0001;
            end
        end
    end

    // High holding latch: pure read of low PC copies high byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter_high_holding_latch_reg <= `RST_BYTE;
        end else if (q2 && exec_valid_reg && kind_reg == K_MOVFW
                     && fa_reg == `FA_PCL) begin
            program_counter_high_holding_latch_reg <= pch_reg;
        end else if (q4 && exec_valid_reg && wr_f_reg
                     && fa_reg == `FA_PROGRAM_COUNTER_HIGH_HOLDING_LATCH) begin
            program_counter_high_holding_latch_reg <= res_reg;
        end
    end

    // Hardware events wait here until the next phase one
    always_comb begin
        hwpend_next = (q1 ? `RST_BYTE : hwpend_reg) | hw_flag_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hwpend_reg <= `RST_BYTE;
        end else begin
            hwpend_reg <= hwpend_next;
        end
    end

    // Hardware flags: set in phase one, software writes in phase four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hwflag_reg <= `RST_BYTE;
        end else if (q1) begin
            hwflag_reg <= hwflag_reg | hwpend_reg;
        end else if (q4 && exec_valid_reg && wr_f_reg
                     && fa_reg == `FA_HWFLAG) begin
            hwflag_reg <= res_reg;
        end
    end

    // General file memory: phase four write or idle bus write
    always_ff @(posedge pclk) begin
        if (q4 && exec_valid_reg && wr_f_reg) begin
            file_mem[fa_reg] <= res_reg;
        end else if (commit && pwrite && paddr == `OFS_FDATA) begin
            file_mem[faddr_reg] <= pwdata[7:0];
        end
    end

    // Completion pulse at the end of each executed cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_done <= 1'b0;
        end else begin
            exec_done <= q4 && exec_valid_reg;
        end
    end

endmodule

// >>> core_exec_params.svh
// Constants for the instruction execution block
`ifndef CORE_EXEC_PARAMS_SVH
`define CORE_EXEC_PARAMS_SVH

// Bus register byte offsets
`define OFS_CTRL 8'h00
`define OFS_INSTR 8'h04
`define OFS_WORK 8'h08
`define OFS_STAT 8'h0C
`define OFS_PC 8'h10
`define OFS_FADDR 8'h14
`define OFS_FDATA 8'h18
`define OFS_HWFLAG 8'h1C

// Control register fields
`define CTRL_RUN_BIT 0

// File addresses of special registers
`define FA_PCL 8'h02
`define FA_PROGRAM_COUNTER_HIGH_HOLDING_LATCH 8'h03
`define FA_ALUSTAT 8'h04
`define FA_HWFLAG 8'h07

// Arithmetic status register flag positions
`define FL_C 0
`define FL_DC 1
`define FL_Z 2
`define FL_OV 3

// Flag masks per instruction
`define FMASK_ALL 8'h0F
`define FMASK_Z 8'h04
`define FMASK_NONE 8'h00

// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
`define RST_INSTR 16'h0000

// Opcode high-byte patterns (casez)
`define OP_NOP 8'b0000_0000
`define OP_MOVWF 8'b0000_0001
`define OP_INCF 8'b0001_010?
`define OP_CLRF 8'b0010_100?
`define OP_NEGATE_WORKING_INSTRUCTION 8'b0010_110?
`define OP_BTG 8'b0011_1???
`define OP_MOVFW 8'b0110_1010
`define OP_BSF 8'b1000_0???
`define OP_BCF 8'b1000_1???

// Constant operands
`define ONE_BYTE 8'h01

`endif

// >>> core_exec_pkg.sv
// Types shared by the instruction execution block
package core_exec_pkg;

    // Instruction cycle phases, one-hot
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_t;

    // Decoded instruction kinds
    typedef enum logic [3:0] {
        K_NOP = 4'h0,
        K_NEGATE_WORKING_INSTRUCTION = 4'h1,
        K_CLRF = 4'h2,
        K_MOVWF = 4'h3,
        K_MOVFW = 4'h4,
        K_INCF = 4'h5,
        K_BSF = 4'h6,
        K_BCF = 4'h7,
        K_BTG = 4'h8
    } kind_t;

endpackage

// >>> q_phase_gen.sv
// Four-phase instruction cycle sequencer
`timescale 1ns/1ps
module q_phase_gen
    import core_exec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic q1,
    output logic q2,
    output logic q3,
    output logic q4
);

    phase_t phase_reg;
    phase_t phase_next;

    // Advance one phase per oscillator period while running
    always_comb begin
        case (phase_reg)
            PH_Q1: phase_next = PH_Q2;
            PH_Q2: phase_next = PH_Q3;
            PH_Q3: phase_next = PH_Q4;
            PH_Q4: phase_next = PH_Q1;
            default: phase_next = PH_Q1;
        endcase
    end

    // Phase register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= PH_Q1;
        end else if (run) begin
            phase_reg <= phase_next;
        end
    end

    // One-cycle phase enables
    assign q1 = run && (phase_reg == PH_Q1);
    assign q2 = run && (phase_reg == PH_Q2);
    assign q3 = run && (phase_reg == PH_Q3);
    assign q4 = run && (phase_reg == PH_Q4);

endmodule

// >>> exec_monitor.sv
// Bus and execution checker for the instruction execution block
`timescale 1ns/1ps
`include "core_exec_params.svh"
module exec_monitor
    import core_exec_pkg::*;
#(
    parameter int FILE_DEPTH = 256
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] hw_flag_set,
    input wire logic exec_done
);
    logic run_reg;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Completed transfers and the decoded register window
    wire commit = psel && penable && pready;
    wire mapped = (paddr <= `OFS_HWFLAG) && (paddr[1:0] == 2'b00);

    // Run bit as last written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= 1'b0;
        end else if (commit && pwrite && paddr == `OFS_CTRL) begin
            run_reg <= pwdata[`CTRL_RUN_BIT];
        end
    end

    // Instruction handed over while running, and the quiet after a pulse
    sequence s_instr_commit;
        commit && pwrite && paddr == `OFS_INSTR && run_reg;
    endsequence
    sequence s_done_quiet;
        !exec_done [*3];
    endsequence

    property p_instr_done;
        s_instr_commit |-> ##[2:12] exec_done;
    endproperty
    property p_done_gap;
        exec_done |=> s_done_quiet;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_ready_access;
        pready |-> psel && penable && $past(psel) && $past(penable);
    endproperty
    property p_err_unmapped;
        pready && !mapped |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    property p_ok_mapped;
        pready && mapped |-> !pslverr;
    endproperty
    property p_stat_width;
        pready && !pwrite && paddr == `OFS_STAT |-> prdata[31:8] == 24'h0;
    endproperty
    property p_ctrl_read;
        pready && !pwrite && paddr == `OFS_CTRL |->
            prdata == {31'h0, run_reg};
    endproperty
    property p_no_done_stopped;
        exec_done |-> $past(run_reg, 4) || $past(run_reg, 2);
    endproperty

    a_instr_done: assert property (p_instr_done)
        else $error("instruction did not complete in time");
    a_done_gap: assert property (p_done_gap)
        else $error("completions closer than four phases");
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held longer than one cycle");
    a_ready_access: assert property (p_ready_access)
        else $error("ready outside an access phase");
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (p_ok_mapped)
        else $error("mapped access refused");
    a_stat_width: assert property (p_stat_width)
        else $error("status read wider than one byte");
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control readback differs from last write");
    a_no_done_stopped: assert property (p_no_done_stopped)
        else $error("completion while the phase sequencer was stopped");
endmodule

// >>> cpu_instruction_execution_test.sv
// Self-checking bench for the instruction execution block
`timescale 1ns/1ps
`include "core_exec_params.svh"
module cpu_instruction_execution_test;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, exec_done, err;
    logic [7:0] paddr, hw_flag_set;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] bop [3] = '{16'h8122, 16'h8F22, 16'h3822};
    logic [7:0] bexp [3] = '{8'hA7, 8'h27, 8'h26};
    int n_fail = 0;
    int comparisons = 0;

    // 100 MHz clock
    always #5 pclk = ~pclk;

    cpu_instruction_execution #(.FILE_DEPTH(256)) cpu_instruction_execution_i (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .hw_flag_set(hw_flag_set),
        .exec_done(exec_done)
    );

    // Verdict and end of run
    task final_report;
        if (n_fail == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Compare one register value
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; data and error taken at the ready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 200) begin
                n_fail++;
                final_report;
            end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask

    // Hand over one instruction and wait for its completion pulse
    task exec(input logic [15:0] ins);
        int n;
        n = 0;
        wr(`OFS_INSTR, {16'h0, ins});
        while (exec_done !== 1'b1) begin
            n++;
            if (n > 40) begin
                n_fail++;
                final_report;
            end
            @(posedge pclk);
        end
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hw_flag_set = 8'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`OFS_STAT, ALL, 32'h0);
        rdc(`OFS_PC, ALL, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        wr(`OFS_CTRL, 32'h1);
        rdc(`OFS_CTRL, ALL, 32'h1);
        // Negate into both places, then into the file only
        wr(`OFS_WORK, 32'h3A);
        wr(`OFS_FADDR, 32'h20);
        wr(`OFS_FDATA, 32'hAB);
        exec(16'h2C20);
        rdc(`OFS_WORK, ALL, 32'hC6);
        rdc(`OFS_FDATA, ALL, 32'hC6);
        wr(`OFS_WORK, 32'h3A);
        wr(`OFS_FADDR, 32'h21);
        exec(16'h2D21);
        rdc(`OFS_FDATA, ALL, 32'hC6);
        rdc(`OFS_WORK, ALL, 32'h3A);
        wr(`OFS_WORK, 32'h0);
        exec(16'h2C21);
        rdc(`OFS_STAT, 32'h4, 32'h4);
        rdc(`OFS_FDATA, ALL, 32'h0);
        // Clearing the status register leaves only the zero flag
        exec(16'h2904);
        rdc(`OFS_STAT, ALL, 32'h04);
        // Bit set, clear and toggle keep the other bits
        wr(`OFS_FADDR, 32'h22);
        wr(`OFS_FDATA, 32'hA5);
        for (int i = 0; i < 3; i++) begin
            exec(bop[i]);
            rdc(`OFS_FDATA, ALL, {24'h0, bexp[i]});
        end
        // Hardware flag survives a bit set on its own register
        @(posedge pclk);
        hw_flag_set <= 8'h10;
        @(posedge pclk);
        hw_flag_set <= 8'h00;
        exec(16'h8007);
        rdc(`OFS_HWFLAG, ALL, 32'h11);
        // Hardware event lands while a bit clear waits in the holding slot for its register
        fork
            exec(16'h8807);
            begin
                repeat (6) @(posedge pclk);
                hw_flag_set <= 8'h20;
                @(posedge pclk);
                hw_flag_set <= 8'h00;
            end
        join
        rdc(`OFS_HWFLAG, ALL, 32'h30);
        // Low program counter written, read and modified
        wr(`OFS_WORK, 32'h12);
        exec(16'h0103);
        wr(`OFS_WORK, 32'h40);
        exec(16'h0102);
        rdc(`OFS_PC, ALL, 32'h12_1240);
        wr(`OFS_WORK, 32'h55);
        exec(16'h0103);
        exec(16'h6A02);
        rdc(`OFS_PC, ALL, 32'h12_1242);
        rdc(`OFS_WORK, ALL, 32'h41);
        wr(`OFS_WORK, 32'h34);
        exec(16'h0103);
        exec(16'h1502);
        rdc(`OFS_PC, ALL, 32'h34_3444);
        final_report;
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        final_report;
    end
endmodule

bind cpu_instruction_execution exec_monitor #(.FILE_DEPTH(FILE_DEPTH))
    exec_monitor_i (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .hw_flag_set(hw_flag_set),
    .exec_done(exec_done)
);
